/* hw/laie_alu.sv */
`timescale 1ns/10ps
module laie_alu (
  input laie_pkg::laie_alu_mode_t mode,
  input wire logic [2:0] op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input laie_pkg::laie_flags_t flags_in,
  output logic [7:0] result,
  output laie_pkg::laie_flags_t flags_out,
  output logic write_back
);
  import laie_pkg::*;

  // Nine-bit sum so bit 8 is carry out or borrow out
  always_comb begin
    logic [DATA_W:0] wide;
    wide = '0;
    result = a;
    flags_out = flags_in;
    write_back = 1'b0;
    case (mode)
      MODE_ARITH: begin
        case (op)
          OP_ADD: wide = {1'b0, a} + {1'b0, b};
          OP_ADC: wide = {1'b0, a} + {1'b0, b} + 9'(flags_in.carry);
          OP_SUB: wide = {1'b0, a} - {1'b0, b};
          OP_SBB: wide = {1'b0, a} - {1'b0, b} - 9'(flags_in.carry);
          OP_AND: wide = {1'b0, a & b};
          OP_XOR: wide = {1'b0, a ^ b};
          OP_OR: wide = {1'b0, a | b};
          default: wide = {1'b0, a} - {1'b0, b};
        endcase
        result = wide[DATA_W-1:0];
        flags_out = laie_flags_of(wide[DATA_W], result);
        write_back = (op != OP_CMP);
      end
      MODE_INC: begin
        result = a + ONE_BYTE;
        flags_out = laie_flags_of(flags_in.carry, result);
        write_back = 1'b1;
      end
      MODE_DEC: begin
        result = a - ONE_BYTE;
        flags_out = laie_flags_of(flags_in.carry, result);
        write_back = 1'b1;
      end
      default: begin
        // Rotates touch carry only
        case (op[1:0])
          ROT_LEFT: result = {a[6:0], a[7]};
          ROT_RIGHT: result = {a[0], a[7:1]};
          ROT_LEFT_CARRY: result = {a[6:0], flags_in.carry};
          default: result = {flags_in.carry, a[7:1]};
        endcase
        flags_out.carry = op[0] ? a[0] : a[7];
        write_back = 1'b1;
      end
    endcase
  end
endmodule

/* hw/laie_exec.sv */
`timescale 1ns/10ps
module laie_exec (
  input wire logic ref_clk,
  input wire logic rst,
  output laie_pkg::laie_bus_req_t bus_req,
  input wire logic bus_ack,
  input wire logic [7:0] bus_rdata,
  input wire logic [1:0] flag_select_code,
  output logic flag_selected,
  output laie_pkg::laie_flags_t flags,
  output logic [7:0] acc_value,
  output logic [13:0] pc_value,
  output logic halted,
  output logic instr_done
);
  import laie_pkg::*;

  // Machine state
  laie_state_t state_reg;
  laie_state_t state_next;
  logic [ADDR_W-1:0] pc_reg;
  logic [ADDR_W-1:0] pc_next;
  logic [DATA_W-1:0] ir_reg;
  logic [DATA_W-1:0] ir_next;
  laie_flags_t flags_reg;
  laie_flags_t flags_next;
  logic [DATA_W-1:0] hold_reg;
  logic [DATA_W-1:0] hold_next;
  laie_bus_req_t bus_req_reg;
  laie_bus_req_t bus_req_next;
  logic done_reg;
  logic done_next;

  // Instruction fields
  logic [1:0] grp;
  logic [2:0] dst_field;
  logic [2:0] src_field;

  // Register file ports
  logic rf_wr_en;
  logic [2:0] rf_wr_idx;
  logic [DATA_W-1:0] rf_wr_data;
  logic [2:0] rf_rd_idx;
  logic [DATA_W-1:0] rf_rd_data;
  logic [DATA_W-1:0] acc_data;
  logic [DATA_W-1:0] high_ptr;
  logic [DATA_W-1:0] low_ptr;
  logic [ADDR_W-1:0] mem_addr;

  // ALU ports
  laie_alu_mode_t alu_mode;
  logic [DATA_W-1:0] alu_a;
  logic [DATA_W-1:0] alu_b;
  logic [DATA_W-1:0] alu_result;
  laie_flags_t alu_flags;
  logic alu_write_back;
  logic [2:0] alu_target;

  assign grp = ir_reg[7:6];
  assign dst_field = ir_reg[5:3];
  assign src_field = ir_reg[2:0];

  // Pointer pair forms the operand address; top bits of high are unused
  assign mem_addr = {high_ptr[HIGH_ADDR_W-1:0], low_ptr};

  laie_regfile u_regfile (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(rf_wr_en),
    .wr_idx(rf_wr_idx),
    .wr_data(rf_wr_data),
    .rd_idx(rf_rd_idx),
    .rd_data(rf_rd_data),
    .acc_data(acc_data),
    .high_ptr(high_ptr),
    .low_ptr(low_ptr)
  );

  laie_alu u_alu (
    .mode(alu_mode),
    .op(dst_field),
    .a(alu_a),
    .b(alu_b),
    .flags_in(flags_reg),
    .result(alu_result),
    .flags_out(alu_flags),
    .write_back(alu_write_back)
  );

  // The whole 00 group (inc, dec, rotate, immediate) reads the destination; move and ALU forms read the source
  always_comb begin
    if (grp == GRP_IMM_INC) begin
      rf_rd_idx = dst_field;
    end else begin
      rf_rd_idx = src_field;
    end
  end

  // ALU steering from the opcode group
  always_comb begin
    alu_mode = MODE_ROT;
    alu_a = acc_data;
    alu_target = REG_ACC;
    if (grp == GRP_ALU) begin
      alu_mode = MODE_ARITH;
    end else if (src_field == LOW_INC) begin
      alu_mode = MODE_INC;
      alu_a = rf_rd_data;
      alu_target = dst_field;
    end else if (src_field == LOW_DEC) begin
      alu_mode = MODE_DEC;
      alu_a = rf_rd_data;
      alu_target = dst_field;
    end
  end

  // Memory operand arrives on the read data; otherwise a register
  always_comb begin
    if (state_reg == ST_READ_MEM) begin
      alu_b = bus_rdata;
    end else begin
      alu_b = rf_rd_data;
    end
  end

  // Sequencer: one state per bus cycle, plus a decode step and a halt state
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    ir_next = ir_reg;
    flags_next = flags_reg;
    hold_next = hold_reg;
    done_next = 1'b0;
    rf_wr_en = 1'b0;
    rf_wr_idx = dst_field;
    rf_wr_data = rf_rd_data;
    case (state_reg)
      ST_FETCH: begin
        if (bus_ack) begin
          ir_next = bus_rdata;
          pc_next = pc_reg + PC_STEP;
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_FETCH;
        done_next = 1'b1;
        case (grp)
          GRP_MOVE: begin
            if (laie_is_mem(dst_field) && laie_is_mem(src_field)) begin
              state_next = ST_HALT;
              done_next = 1'b0;
            end else if (laie_is_mem(src_field)) begin
              state_next = ST_READ_MEM;
              done_next = 1'b0;
            end else if (laie_is_mem(dst_field)) begin
              hold_next = rf_rd_data;
              state_next = ST_WRITE;
              done_next = 1'b0;
            end else if (dst_field != src_field) begin
              rf_wr_en = 1'b1;
            end
            // Equal codes fall through untouched
          end
          GRP_ALU: begin
            if (laie_is_mem(src_field)) begin
              state_next = ST_READ_MEM;
              done_next = 1'b0;
            end else begin
              flags_next = alu_flags;
              rf_wr_en = alu_write_back;
              rf_wr_idx = REG_ACC;
              rf_wr_data = alu_result;
            end
          end
          GRP_IMM_INC: begin
            case (src_field)
              LOW_IMM: begin
                state_next = ST_READ_IMM;
                done_next = 1'b0;
              end
              LOW_INC, LOW_DEC: begin
                if (dst_field == REG_ACC) begin
                  // Code 000 here is a halt, not an accumulator step
                  state_next = ST_HALT;
                  done_next = 1'b0;
                end else if (!laie_is_mem(dst_field)) begin
                  flags_next = alu_flags;
                  rf_wr_en = 1'b1;
                  rf_wr_idx = alu_target;
                  rf_wr_data = alu_result;
                end
                // Memory cannot be stepped, so code 111 does nothing
              end
              LOW_ROT: begin
                if (!dst_field[2]) begin
                  flags_next = alu_flags;
                  rf_wr_en = 1'b1;
                  rf_wr_idx = REG_ACC;
                  rf_wr_data = alu_result;
                end
              end
              default: begin
                // Returns and restarts belong to another block
              end
            endcase
          end
          default: begin
            // Jumps, calls and I/O are handled elsewhere
          end
        endcase
      end
      ST_READ_MEM: begin
        if (bus_ack) begin
          state_next = ST_FETCH;
          done_next = 1'b1;
          if (grp == GRP_MOVE) begin
            rf_wr_en = 1'b1;
            rf_wr_data = bus_rdata;
          end else begin
            flags_next = alu_flags;
            rf_wr_en = alu_write_back;
            rf_wr_idx = REG_ACC;
            rf_wr_data = alu_result;
          end
        end
      end
      ST_READ_IMM: begin
        if (bus_ack) begin
          pc_next = pc_reg + PC_STEP;
          if (laie_is_mem(dst_field)) begin
            hold_next = bus_rdata;
            state_next = ST_WRITE;
          end else begin
            rf_wr_en = 1'b1;
            rf_wr_data = bus_rdata;
            state_next = ST_FETCH;
            done_next = 1'b1;
          end
        end
      end
      ST_WRITE: begin
        if (bus_ack) begin
          state_next = ST_FETCH;
          done_next = 1'b1;
        end
      end
      ST_HALT: begin
        // Held until reset; no wake-up source in this block
      end
      default: begin
        state_next = ST_FETCH;
      end
    endcase
  end

  // Next bus request follows the state being entered
  always_comb begin
    bus_req_next.valid = 1'b1;
    bus_req_next.cycle = CYC_IDLE;
    bus_req_next.addr = pc_next;
    bus_req_next.wdata = hold_next;
    case (state_next)
      ST_FETCH: begin
        bus_req_next.cycle = CYC_FETCH;
      end
      ST_READ_IMM: begin
        bus_req_next.cycle = CYC_MEM_READ;
      end
      ST_READ_MEM: begin
        bus_req_next.cycle = CYC_MEM_READ;
        bus_req_next.addr = mem_addr;
      end
      ST_WRITE: begin
        bus_req_next.cycle = CYC_MEM_WRITE;
        bus_req_next.addr = mem_addr;
      end
      default: begin
        bus_req_next.valid = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_FETCH;
    end else begin
      state_reg <= state_next;
    end
  end

  // Program counter and instruction byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_reg <= PC_RESET;
      ir_reg <= REG_RESET;
    end else begin
      pc_reg <= pc_next;
      ir_reg <= ir_next;
    end
  end

  // Condition flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Byte waiting for a write cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= REG_RESET;
    end else begin
      hold_reg <= hold_next;
    end
  end

  // Request is registered so memory sees glitch-free address and type
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_req_reg.valid <= 1'b1;
      bus_req_reg.cycle <= CYC_FETCH;
      bus_req_reg.addr <= PC_RESET;
      bus_req_reg.wdata <= REG_RESET;
    end else begin
      bus_req_reg <= bus_req_next;
    end
  end

  // Completion pulse, one cycle per finished instruction
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
    end
  end

  // Selected condition by its two-bit code
  always_comb begin
    case (flag_select_code)
      FLAG_CARRY: flag_selected = flags_reg.carry;
      FLAG_ZERO: flag_selected = flags_reg.zero;
      FLAG_SIGN: flag_selected = flags_reg.sign;
      default: flag_selected = flags_reg.parity;
    endcase
  end

  assign bus_req = bus_req_reg;
  assign flags = flags_reg;
  assign acc_value = acc_data;
  assign pc_value = pc_reg;
  assign halted = (state_reg == ST_HALT);
  assign instr_done = done_reg;
endmodule

/* hw/laie_regfile.sv */
`timescale 1ns/10ps
module laie_regfile (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [7:0] acc_data,
  output logic [7:0] high_ptr,
  output logic [7:0] low_ptr
);
  import laie_pkg::*;

  logic [DATA_W-1:0] file_reg [NUM_REGS];

  // One flop bank per scratch-pad register
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          file_reg[g] <= REG_RESET;
        end else if (wr_en && wr_idx == 3'(g)) begin
          file_reg[g] <= wr_data;
        end
      end
    end
  endgenerate

  // Code 111 has no storage behind it, so it reads as zero
  assign rd_data = laie_is_mem(rd_idx) ? REG_RESET : file_reg[rd_idx];
  assign acc_data = file_reg[REG_ACC];
  assign high_ptr = file_reg[REG_HIGH];
  assign low_ptr = file_reg[REG_LOW];
endmodule

/* pkg/laie_pkg.sv */
// What this block does
// - Registers coded 000 acc, 001..100 B-E, 101 high, 110 low; 111 memory.
// - Flag select code: 00 carry, 01 zero, 10 sign, 11 parity.
// - Memory operand address comes from high and low pointer registers.
// - 11 DDD SOURCE_FIELD copies source into destination in one fetch cycle.
// - Move with equal source and destination changes nothing.
// - Source 111 loads destination from memory: fetch then read; 11 111 111 halts.
// - Destination 111 stores source to memory: fetch then write.
// - 00 DDD 110 reads second byte into destination: fetch then read.
// - 00 111 110 reads second byte then writes it to memory.
// - 00 DDD 000 increments register, updates zero sign parity, carry kept; 00 000 000 halts instead.
// - 00 DDD 001 decrements register, updates zero sign parity, carry kept; 00 000 001 halts instead.
// - Accumulator group operations set all four flags from the result.
// - AND, XOR and OR clear the carry flag.
// - Rotates change only carry; zero, sign, parity kept.
// - 10 OOO SOURCE_FIELD with register source completes in one fetch cycle.
// - Op 000 adds operand; op 001 adds operand plus carry.
// - Op 010 subtracts operand; op 011 subtracts operand and carry.
// - Ops 100, 101, 110 store AND, XOR, OR into accumulator.
// - Op 111 compares: flags only; zero means equal, carry means lower.
// - ALU source 111 takes operand from memory: fetch then read.
// - Sign is result bit 7; parity set on even parity.
package laie_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 14;
  localparam int NUM_REGS = 7;
  localparam int HIGH_ADDR_W = ADDR_W - DATA_W;
  localparam logic [2:0] REG_ACC = 3'h0;
  localparam logic [2:0] REG_HIGH = 3'h5;
  localparam logic [2:0] REG_LOW = 3'h6;
  localparam logic [2:0] REG_MEM = 3'h7;
  localparam logic [1:0] FLAG_CARRY = 2'h0;
  localparam logic [1:0] FLAG_ZERO = 2'h1;
  localparam logic [1:0] FLAG_SIGN = 2'h2;
  localparam logic [1:0] FLAG_PARITY = 2'h3;
  localparam logic [1:0] GRP_IMM_INC = 2'h0;
  localparam logic [1:0] GRP_ALU = 2'h2;
  localparam logic [1:0] GRP_MOVE = 2'h3;
  localparam logic [2:0] LOW_INC = 3'h0;
  localparam logic [2:0] LOW_DEC = 3'h1;
  localparam logic [2:0] LOW_ROT = 3'h2;
  localparam logic [2:0] LOW_IMM = 3'h6;
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_ADC = 3'h1;
  localparam logic [2:0] OP_SUB = 3'h2;
  localparam logic [2:0] OP_SBB = 3'h3;
  localparam logic [2:0] OP_AND = 3'h4;
  localparam logic [2:0] OP_XOR = 3'h5;
  localparam logic [2:0] OP_OR = 3'h6;
  localparam logic [2:0] OP_CMP = 3'h7;
  localparam logic [1:0] ROT_LEFT = 2'h0;
  localparam logic [1:0] ROT_RIGHT = 2'h1;
  localparam logic [1:0] ROT_LEFT_CARRY = 2'h2;
  localparam logic [1:0] ROT_RIGHT_CARRY = 2'h3;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] PC_RESET = 14'h0000;
  localparam logic [ADDR_W-1:0] PC_STEP = 14'h0001;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_EXEC = 3'b001,
    ST_READ_MEM = 3'b010,
    ST_READ_IMM = 3'b011,
    ST_WRITE = 3'b100,
    ST_HALT = 3'b101
  } laie_state_t;

  typedef enum logic [1:0] {
    CYC_FETCH = 2'b00,
    CYC_MEM_READ = 2'b01,
    CYC_MEM_WRITE = 2'b10,
    CYC_IDLE = 2'b11
  } laie_cycle_t;

  typedef enum logic [1:0] {
    MODE_ARITH = 2'b00,
    MODE_INC = 2'b01,
    MODE_DEC = 2'b10,
    MODE_ROT = 2'b11
  } laie_alu_mode_t;

  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic parity;
  } laie_flags_t;

  typedef struct packed {
    logic valid;
    laie_cycle_t cycle;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } laie_bus_req_t;

  localparam laie_flags_t FLAGS_RESET = 4'h0;

  // Code 111 names the pointer-addressed byte, not a register
  function automatic logic laie_is_mem(input logic [2:0] code);
    return code == REG_MEM;
  endfunction

  // Zero, sign and parity always follow the result the same way
  function automatic laie_flags_t laie_flags_of(input logic carry, input logic [DATA_W-1:0] res);
    laie_flags_t f;
    f.carry = carry;
    f.zero = (res == REG_RESET);
    f.sign = res[DATA_W-1];
    f.parity = ~^res;
    return f;
  endfunction
endpackage

/* tb/laie_exec_asserts.sv */
`timescale 1ns/10ps
module laie_exec_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input laie_pkg::laie_bus_req_t bus_req,
  input wire logic bus_ack,
  input wire logic [7:0] bus_rdata,
  input wire logic [1:0] flag_select_code,
  input wire logic flag_selected,
  input laie_pkg::laie_flags_t flags,
  input wire logic [7:0] acc_value,
  input wire logic halted,
  input wire logic instr_done
);
  import laie_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic fa;
  // Opcode byte taken on this edge
  assign fa = bus_req.valid && bus_ack && bus_req.cycle == CYC_FETCH;

  req_hold_a: assert property (bus_req.valid && !bus_ack |=> $stable(bus_req))
    else $error("request moved before ack");
  idle_code_a: assert property (!bus_req.valid |-> bus_req.cycle == CYC_IDLE)
    else $error("idle cycle not marked idle");
  flag_pick_a: assert property (flag_selected == (flag_select_code[1] ?
    (flag_select_code[0] ? flags.parity : flags.sign) : (flag_select_code[0] ? flags.zero : flags.carry)))
    else $error("wrong flag selected");
  decode_gap_a: assert property (fa |=> !bus_req.valid)
    else $error("no decode gap after fetch");
  step_one_a: assert property (fa ##2 (bus_req.valid && bus_req.cycle == CYC_FETCH) |->
    bus_req.addr == $past(bus_req.addr, 2) + 14'h0001)
    else $error("one byte op took extra cycles");
  read_next_a: assert property (bus_req.valid && bus_ack && bus_req.cycle == CYC_MEM_READ |=>
    bus_req.valid && (bus_req.cycle == CYC_MEM_WRITE || instr_done))
    else $error("read not followed by write or end");
  write_next_a: assert property (bus_req.valid && bus_ack && bus_req.cycle == CYC_MEM_WRITE |=>
    bus_req.valid && bus_req.cycle == CYC_FETCH && instr_done)
    else $error("write not followed by fetch");
  halt_hold_a: assert property (halted |=> halted && !bus_req.valid)
    else $error("halt left or bus active");
  rot_keep_a: assert property (fa && bus_rdata[7:5] == 3'h0 && bus_rdata[2:0] == 3'h2 |->
    ##2 flags[2:0] == $past(flags[2:0], 2))
    else $error("rotate touched zero sign parity");
  incdec_carry_a: assert property (fa && bus_rdata[7:6] == 2'h0 && bus_rdata[2:1] == 2'h0 |->
    ##2 flags.carry == $past(flags.carry, 2))
    else $error("inc or dec changed carry");
  logic_carry_a: assert property (fa && bus_rdata[7:5] == 3'h5 && bus_rdata[4:3] != 2'h3 &&
    bus_rdata[2:0] != 3'h7 |-> ##2 !flags.carry)
    else $error("logic op left carry set");
  cmp_keep_a: assert property (fa && bus_rdata[7:3] == 5'h17 && bus_rdata[2:0] != 3'h7 |->
    ##2 acc_value == $past(acc_value, 2))
    else $error("compare wrote accumulator");
  move_flags_a: assert property (fa && bus_rdata[7:6] == 2'h3 && bus_rdata[2:0] != 3'h7 &&
    bus_rdata[5:3] != 3'h7 |-> ##2 flags == $past(flags, 2))
    else $error("move changed flags");
endmodule

bind laie_exec laie_exec_asserts u_laie_exec_asserts (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
  .bus_ack(bus_ack), .bus_rdata(bus_rdata), .flag_select_code(flag_select_code),
  .flag_selected(flag_selected), .flags(flags), .acc_value(acc_value), .halted(halted),
  .instr_done(instr_done));

/* tb/laie_exec_tb.sv */
`timescale 1ns/10ps
module laie_exec_tb;
  import laie_pkg::*;
  logic ref_clk, rst, bus_ack, flag_selected, halted, instr_done;
  logic [1:0] flag_select_code, slow;
  logic [7:0] bus_rdata, acc_value;
  laie_bus_req_t bus_req;
  laie_flags_t flags, f;
  int mismatches, num_checks;
  logic [7:0] r [0:7];
  logic [7:0] m [0:16383];
  logic [13:0] pc, pc_value;
  logic [25:0] nt;
  logic [25:0] notes [$];
  logic [13:0] wrs [$];

  laie_exec u_laie_exec (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .flag_select_code(flag_select_code), .flag_selected(flag_selected),
    .flags(flags), .acc_value(acc_value), .pc_value(pc_value), .halted(halted), .instr_done(instr_done));
  laie_mem_model u_laie_mem_model (.ref_clk(ref_clk), .bus_req(bus_req), .slow(slow),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [13:0] hl();
    return {r[5][5:0], r[6]};
  endfunction

  // Keeps random destinations off the high pointer so data stays above the program
  function automatic logic [2:0] nh(input logic [2:0] x);
    return (x == 3'h5 || x == 3'h7) ? 3'h6 : x;
  endfunction

  function automatic void zsp(input logic [7:0] v);
    f.zero = (v == 8'h00);
    f.sign = v[7];
    f.parity = ~^v;
  endfunction

  task automatic put(input logic [7:0] b);
    m[pc] = b;
    u_laie_mem_model.mem[pc] = b;
    pc = pc + 14'h0001;
  endtask

  // Reference step: places the instruction and notes the expected outcome
  task automatic emit(input logic [7:0] op, input logic [7:0] imm);
    logic [2:0] d, s;
    logic [8:0] t;
    logic [7:0] b;
    d = op[5:3];
    s = op[2:0];
    put(op);
    if (op[7:6] == 2'h3) begin
      if (s == 3'h7) r[d] = m[hl()];
      else if (d == 3'h7) begin
        m[hl()] = r[s];
        wrs.push_back(hl());
      end else r[d] = r[s];
    end else if (op[7:6] == 2'h0) begin
      if (s == 3'h6) begin
        put(imm);
        if (d == 3'h7) begin
          m[hl()] = imm;
          wrs.push_back(hl());
        end else r[d] = imm;
      end else if (s == 3'h2) begin
        case (d[1:0])
          2'h0: {f.carry, r[0]} = {r[0][7], r[0][6:0], r[0][7]};
          2'h1: {f.carry, r[0]} = {r[0][0], r[0][0], r[0][7:1]};
          2'h2: {f.carry, r[0]} = {r[0], f.carry};
          default: {r[0], f.carry} = {f.carry, r[0]};
        endcase
      end else begin
        r[d] = (s == 3'h0) ? r[d] + 8'h01 : r[d] - 8'h01;
        zsp(r[d]);
      end
    end else begin
      b = (s == 3'h7) ? m[hl()] : r[s];
      case (d)
        3'h0: t = r[0] + b;
        3'h1: t = r[0] + b + f.carry;
        3'h2, 3'h7: t = r[0] - b;
        3'h3: t = r[0] - b - f.carry;
        3'h4: t = {1'b0, r[0] & b};
        3'h5: t = {1'b0, r[0] ^ b};
        default: t = {1'b0, r[0] | b};
      endcase
      f.carry = t[8];
      zsp(t[7:0]);
      if (d != 3'h7) r[0] = t[7:0];
    end
    notes.push_back({r[0], f, pc});
  endtask

  // One program from reset to the given halt code
  task automatic run(input logic [7:0] halt_op);
    logic [7:0] d;
    int k;
    @(posedge ref_clk);
    #1 rst = 1'b1;
    foreach (r[i]) r[i] = 8'h00;
    f = 4'h0;
    pc = 14'h0000;
    wrs.delete();
    slow = 2'($urandom % 3);
    emit(8'h2E, 8'h10 | 8'($urandom));
    repeat (200) begin
      d = 8'($urandom);
      case ($urandom % 8)
        0: emit({2'h3, nh(d[5:3]), d[2:0]}, 8'h00);
        1: emit({5'h1F, nh(d[2:0])}, 8'h00);
        2: emit({2'h0, d[5:3], 3'h6}, (d[5:3] == 3'h5) ? 8'h10 | 8'($urandom) : 8'($urandom));
        3: emit({2'h0, (d[5:3] == 3'h0) ? 3'h1 : nh(d[5:3]), 2'h0, d[0]}, 8'h00);
        4: emit({3'h0, d[1:0], 3'h2}, 8'h00);
        default: emit({2'h2, d[5:0]}, 8'h00);
      endcase
    end
    put(halt_op);
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    for (k = 0; k < 8000 && halted !== 1'b1; k++) @(posedge ref_clk);
    if (halted !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
    repeat (4) @(posedge ref_clk);
    check(26'(notes.size()), 26'h0);
    check(26'(bus_req.valid), 26'h0);
    foreach (wrs[i]) check(26'(u_laie_mem_model.mem[wrs[i]]), 26'(m[wrs[i]]));
  endtask

  // Oldest note against the state shown when an instruction ends
  always @(posedge ref_clk) begin
    if (rst === 1'b0 && instr_done === 1'b1) begin
      if (notes.size() == 0) check(26'h0, 26'h1);
      else begin
        nt = notes.pop_front();
        check(26'(acc_value), 26'(nt[25:18]));
        check(26'(flags), 26'(nt[17:14]));
        check(26'(bus_req.addr), 26'(nt[13:0]));
        check(26'(pc_value), 26'(nt[13:0]));
      end
    end
  end

  always @(posedge ref_clk) #1 flag_select_code = 2'($urandom);

  initial begin
    rst = 1'b1;
    flag_select_code = 2'h0;
    slow = 2'h0;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(12));
    for (int a = 4096; a < 16384; a++) begin
      m[a] = 8'($urandom);
      u_laie_mem_model.mem[a] = m[a];
    end
    run(8'hFF);
    run(8'h00);
    run(8'h01);
    end_of_test();
  end
endmodule

/* tb/laie_mem_model.sv */
`timescale 1ns/10ps
module laie_mem_model (
  input wire logic ref_clk,
  input laie_pkg::laie_bus_req_t bus_req,
  input wire logic [1:0] slow,
  output logic bus_ack,
  output logic [7:0] bus_rdata
);
  import laie_pkg::*;
  logic [7:0] mem [0:16383];
  logic [1:0] wait_reg;
  initial begin
    bus_ack = 1'b0;
    bus_rdata = 8'h00;
    wait_reg = 2'h0;
  end
  // Read data toggles outside the ack cycle so stale bytes never look valid
  always @(posedge ref_clk) begin
    bus_rdata <= ~bus_rdata;
    bus_ack <= 1'b0;
    if (bus_req.valid && !bus_ack) begin
      if (wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
      else begin
        bus_ack <= 1'b1;
        wait_reg <= slow;
        if (bus_req.cycle == CYC_MEM_WRITE) mem[bus_req.addr] <= bus_req.wdata;
        else bus_rdata <= mem[bus_req.addr];
      end
    end
  end
endmodule
